// ---- rtl/cbc_host.sv ----
// Host controller driving the character block check unit over its pins.
// Assumes a 100 MHz clock; device pins are asynchronous to it.
//
// Behaviour
// - Direction pin low reads, high writes
// - Direct select gates transfers and initialisation
// - CRC-12 uses six-bit characters, bit6 zero
// - Parity becomes top bit; none when transparent
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "cbc_host_defs.svh"
`default_nettype none
module cbc_host #(
   parameter int SETUP_CYC  = `CBC_CYC(`CBC_T_SETUP_NS),
   parameter int STROBE_CYC = `CBC_CYC(`CBC_T_STROBE_NS),
   parameter int HOLD_CYC   = `CBC_CYC(`CBC_T_HOLD_NS),
   parameter int RECOV_CYC  = `CBC_CYC(`CBC_T_RECOV_NS)
) (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        ARST_N,
   // Software register port
   input  wire logic [3:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR_STB,
   input  wire logic        RD_STB,
   output logic      [31:0] RDATA,
   // Device data bus
   input  wire logic [7:0]  DATA_I,
   output logic      [7:0]  DATA_O,
   output logic             DATA_OE,
   // Device control pins
   output logic             MONITOR_STROBE_N,
   output logic             DIRECT_SELECT_N,
   output logic             WRITE_DIR,
   output logic      [1:0]  REGISTER_SELECT,
   // Device attention, open drain
   input  wire logic        ATTENTION_N
);

   // Counts must fit the eight-bit down counter
   if (SETUP_CYC < 1 || SETUP_CYC > 256) begin : g_bad_setup
      $error("cbc_host: SETUP_CYC out of range");
   end
   // Strobe must outlast the two-flop bus lag
   if (STROBE_CYC < 3 || STROBE_CYC > 256) begin : g_bad_strobe
      $error("cbc_host: STROBE_CYC out of range");
   end
   if (HOLD_CYC < 1 || HOLD_CYC > 256) begin : g_bad_hold
      $error("cbc_host: HOLD_CYC out of range");
   end
   if (RECOV_CYC < 1 || RECOV_CYC > 256) begin : g_bad_recov
      $error("cbc_host: RECOV_CYC out of range");
   end

   // Down counter load values
   localparam logic [7:0] SETUP_LD  = 8'(SETUP_CYC - 1);
   localparam logic [7:0] STROBE_LD = 8'(STROBE_CYC - 1);
   localparam logic [7:0] HOLD_LD   = 8'(HOLD_CYC - 1);
   localparam logic [7:0] RECOV_LD  = 8'(RECOV_CYC - 1);

   // Current and next state
   cbc_host_pkg::host_s s_q;
   cbc_host_pkg::host_s s_d;

   function automatic logic [7:0] shape_char(input logic [31:0] w);
      logic [7:0] c;
      c = w[`CBC_CTRL_DATA_LSB +: 8];
      // Six-bit characters right justified, bit 6 low
      if (w[`CBC_CTRL_NARROW_BIT])
         c = c & `CBC_NARROW_MASK;
      return c;
   endfunction

   // Synchronisers, counter, register reads, sequencer
   always_comb begin
      s_d        = s_q;
      s_d.att_s1 = ATTENTION_N;
      s_d.att_s2 = s_q.att_s1;
      s_d.din_s1 = DATA_I;
      s_d.din_s2 = s_q.din_s1;
      s_d.rdata  = 32'h0000_0000;
      if (s_q.cnt != 8'h00)
         s_d.cnt = s_q.cnt - 8'h01;

      // Register reads, answered in the next cycle
      if (RD_STB) begin
         case (ADDR)
            `CBC_ADDR_CTRL: begin
               s_d.rdata[`CBC_CTRL_DATA_LSB +: 8] = s_q.dout;
               s_d.rdata[`CBC_CTRL_SEL_LSB +: 2]  = s_q.rsel;
               s_d.rdata[`CBC_CTRL_DIR_BIT]       = s_q.dir;
               s_d.rdata[`CBC_CTRL_MON_BIT]       = s_q.use_mon;
               s_d.rdata[`CBC_CTRL_PAIR_BIT]      = s_q.pair;
            end
            `CBC_ADDR_STATUS: begin
               s_d.rdata[`CBC_STAT_BUSY_BIT] =
                  (s_q.st != cbc_host_pkg::ST_IDLE);
               // Attention is active low on the pin
               s_d.rdata[`CBC_STAT_ATTN_BIT] = ~s_q.att_s2;
            end
            `CBC_ADDR_RESULT:
               s_d.rdata[15:0] = s_q.result;
            default:
               s_d.rdata = 32'h0000_0000;
         endcase
      end

      case (s_q.st)
         cbc_host_pkg::ST_IDLE: begin
            // A request while busy is ignored
            if (WR_STB && ADDR == `CBC_ADDR_CTRL) begin
               s_d.st      = cbc_host_pkg::ST_SETUP;
               s_d.cnt     = SETUP_LD;
               s_d.use_mon = WDATA[`CBC_CTRL_MON_BIT];
               s_d.pair    = WDATA[`CBC_CTRL_PAIR_BIT];
               s_d.second  = 1'b0;
               s_d.dir     = WDATA[`CBC_CTRL_DIR_BIT];
               s_d.oe      = WDATA[`CBC_CTRL_DIR_BIT];
               s_d.dout    = shape_char(WDATA);
               s_d.result  = 16'h0000;
               // Monitor strobe only with select at character reg
               if (WDATA[`CBC_CTRL_MON_BIT])
                  s_d.rsel = `CBC_SEL_CHAR;
               else
                  s_d.rsel = WDATA[`CBC_CTRL_SEL_LSB +: 2];
            end
         end
         cbc_host_pkg::ST_SETUP: begin
            // Address and direction settle before the falling edge
            if (s_q.cnt == 8'h00) begin
               s_d.st  = cbc_host_pkg::ST_STROBE;
               s_d.cnt = STROBE_LD;
               if (s_q.use_mon)
                  s_d.mon_n = 1'b0;
               else
                  s_d.sel_n = 1'b0;
            end
         end
         cbc_host_pkg::ST_STROBE: begin
            // Last low cycle: synced bus holds the byte
            if (s_q.cnt == 8'h00) begin
               s_d.st    = cbc_host_pkg::ST_HOLD;
               s_d.cnt   = HOLD_LD;
               s_d.sel_n = 1'b1;
               s_d.mon_n = 1'b1;
               if (!s_q.dir) begin
                  if (s_q.second)
                     s_d.result[15:8] = s_q.din_s2;
                  else
                     s_d.result[7:0] = s_q.din_s2;
               end
            end
         end
         cbc_host_pkg::ST_HOLD: begin
            // Data held past the rising edge
            if (s_q.cnt == 8'h00) begin
               s_d.st  = cbc_host_pkg::ST_RECOV;
               s_d.cnt = RECOV_LD;
               s_d.oe  = 1'b0;
            end
         end
         cbc_host_pkg::ST_RECOV: begin
            if (s_q.cnt == 8'h00) begin
               // Second access reaches the lower check register
               if (s_q.pair && !s_q.second) begin
                  s_d.st     = cbc_host_pkg::ST_SETUP;
                  s_d.cnt    = SETUP_LD;
                  s_d.second = 1'b1;
                  s_d.oe     = s_q.dir;
               end else begin
                  s_d.st = cbc_host_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            s_d = cbc_host_pkg::STATE_RST;
         end
      endcase
   end

   // Whole state registered, reset to idle
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         s_q <= cbc_host_pkg::STATE_RST;
      else
         s_q <= s_d;
   end

   // Pins and read data straight from flip-flops
   assign RDATA            = s_q.rdata;
   assign DATA_O           = s_q.dout;
   assign DATA_OE          = s_q.oe;
   assign MONITOR_STROBE_N = s_q.mon_n;
   assign DIRECT_SELECT_N  = s_q.sel_n;
   assign WRITE_DIR        = s_q.dir;
   assign REGISTER_SELECT  = s_q.rsel;

endmodule
`default_nettype wire

// ---- common/cbc_host_defs.svh ----
// Constants for the host controller of the character block check unit.
// Assumes a 100 MHz controller clock; included by bare name.
`ifndef CBC_HOST_DEFS_SVH
`define CBC_HOST_DEFS_SVH

`define CBC_CLK_PERIOD_NS   10
// Pin timing in ns (plain defaults)
`define CBC_T_SETUP_NS      20
`define CBC_T_STROBE_NS     300
`define CBC_T_HOLD_NS       20
`define CBC_T_RECOV_NS      500
// Least times round up to whole cycles
`define CBC_CYC(ns) (((ns) + `CBC_CLK_PERIOD_NS - 1) / `CBC_CLK_PERIOD_NS)

// Software register offsets
`define CBC_ADDR_CTRL       4'h0
`define CBC_ADDR_STATUS     4'h4
`define CBC_ADDR_RESULT     4'h8

// Control register fields
`define CBC_CTRL_DATA_LSB   0
`define CBC_CTRL_SEL_LSB    8
`define CBC_CTRL_DIR_BIT    10
`define CBC_CTRL_MON_BIT    11
`define CBC_CTRL_PAIR_BIT   12
`define CBC_CTRL_NARROW_BIT 13

// Status register fields
`define CBC_STAT_BUSY_BIT   0
`define CBC_STAT_ATTN_BIT   1

// Six-bit characters: bits 6 and 7 forced low
`define CBC_NARROW_MASK     8'h3F
// Monitor strobe only reaches the character register
`define CBC_SEL_CHAR        2'h0
`endif

// ---- common/cbc_host_pkg.sv ----
// Types for the host controller of the character block check unit.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package cbc_host_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD,
      ST_RECOV
   } state_e;

   typedef struct packed {
      state_e      st;
      logic [7:0]  cnt;
      logic        pair;
      logic        second;
      logic        use_mon;
      logic [1:0]  rsel;
      logic        dir;
      logic        oe;
      logic        sel_n;
      logic        mon_n;
      logic [7:0]  dout;
      logic [15:0] result;
      logic        att_s1;
      logic        att_s2;
      logic [7:0]  din_s1;
      logic [7:0]  din_s2;
      logic [31:0] rdata;
   } host_s;

   localparam host_s STATE_RST = '{
      st:      ST_IDLE,
      cnt:     8'h00,
      pair:    1'b0,
      second:  1'b0,
      use_mon: 1'b0,
      rsel:    2'h0,
      dir:     1'b0,
      oe:      1'b0,
      sel_n:   1'b1,
      mon_n:   1'b1,
      dout:    8'h00,
      result:  16'h0000,
      att_s1:  1'b1,
      att_s2:  1'b1,
      din_s1:  8'h00,
      din_s2:  8'h00,
      rdata:   32'h0000_0000
   };

endpackage
`default_nettype wire

// ---- tb/cbc_dev_model.sv ----
// Device model: registers behind the two strobes.
// Assumes host pins as driven by cbc_host; edge driven.
`timescale 1ns/100ps
`default_nettype none
module cbc_dev_model (
   // Host pins
   input  wire logic       mon_n,
   input  wire logic       sel_n,
   input  wire logic       wr,
   input  wire logic [1:0] rsel,
   input  wire logic [7:0] dout,
   input  wire logic       oe,
   // Bus level and attention
   output logic      [7:0] din,
   output logic            att_n
);
   logic [7:0] chr = 8'h00, mode = 8'h00, hi = 8'h00, lo = 8'h00;
   logic [7:0] stat = 8'h00, last = 8'h00, rv;
   logic       ptr = 1'h0;
   logic       via_mon = 1'h0;
   assign rv = rsel == 2'h0 ? chr : rsel == 2'h1 ? stat :
               rsel == 2'h2 ? mode : ptr ? lo : hi;
   // Released bus shows the inverted last value
   assign din = oe ? dout : (!sel_n && !wr) ? rv : ~last;
   assign att_n = stat == 8'h00;
   // Note which strobe opened the access
   always @(negedge mon_n or negedge sel_n) via_mon <= !mon_n;
   always @(posedge sel_n or posedge mon_n) begin
      if (via_mon) begin
         if (rsel == 2'h0 && wr == mode[2]) begin
            chr <= din;
            if (din == 8'h10) stat[2] <= 1'h1;
         end
      end else begin
         last <= oe ? dout : rv;
         if (wr && rsel == 2'h0) begin
            chr <= dout;
            if (dout == 8'h10) stat[2] <= 1'h1;
         end
         if (wr && rsel == 2'h1 && dout[0]) begin
            {hi, lo, stat, ptr} <= '0;
         end
         if (!wr && rsel == 2'h1) stat <= 8'h00;
         if (wr && rsel == 2'h2) mode <= dout;
         if (rsel == 2'h3) begin
            ptr <= !ptr;
            if (wr && !ptr) hi <= dout;
            if (wr && ptr) lo <= dout;
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/cbc_host_sva.sv ----
// Pin protocol assertions for the block check host.
// Assumes binding to cbc_host; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module cbc_host_sva (
   // Clock and reset
   input wire logic       CLK,
   input wire logic       ARST_N,
   // Device pins
   input wire logic [7:0] DATA_O,
   input wire logic       DATA_OE,
   input wire logic       MONITOR_STROBE_N,
   input wire logic       DIRECT_SELECT_N,
   input wire logic       WRITE_DIR,
   input wire logic [1:0] REGISTER_SELECT
);
   wire act = !MONITOR_STROBE_N || !DIRECT_SELECT_N;
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   property p_excl; !(!MONITOR_STROBE_N && !DIRECT_SELECT_N); endproperty
   a_excl: assert property (p_excl) else $error("both strobes");
   property p_rd; act && !WRITE_DIR |-> !DATA_OE; endproperty
   a_rd: assert property (p_rd) else $error("drive on read");
   property p_wr; act && WRITE_DIR |-> DATA_OE; endproperty
   a_wr: assert property (p_wr) else $error("no drive on write");
   property p_mon; !MONITOR_STROBE_N |-> REGISTER_SELECT == 2'h0; endproperty
   a_mon: assert property (p_mon) else $error("monitor select");
   property p_setup;
      $rose(act) |-> $stable({WRITE_DIR, REGISTER_SELECT, DATA_O});
   endproperty
   a_setup: assert property (p_setup) else $error("no setup");
   property p_steady;
      act && $past(act) |-> $stable({WRITE_DIR, REGISTER_SELECT, DATA_O});
   endproperty
   a_steady: assert property (p_steady) else $error("unsteady");
   property p_hold; $fell(act) && WRITE_DIR |-> DATA_OE; endproperty
   a_hold: assert property (p_hold) else $error("no hold");
   property p_width; $rose(act) |-> act [*3]; endproperty
   a_width: assert property (p_width) else $error("short strobe");
   property p_gap; $fell(act) |-> !act [*2]; endproperty
   a_gap: assert property (p_gap) else $error("short gap");
endmodule
`default_nettype wire

// ---- tb/test_char_block_check_unit.sv ----
// Self-checking bench for the block check host.
// Assumes device model and checker are compiled first.
`timescale 1ns/100ps
`include "cbc_host_defs.svh"
`default_nettype none
module test_char_block_check_unit;
   logic        clk = 1'h0, arst_n = 1'h0, wr_stb = 1'h0, rd_stb = 1'h0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic [7:0]  d_i, d_o, m, q[$];
   logic [1:0]  rs;
   logic        oe, mon_n, sel_n, wdir, att_n;
   int          err_total = 0, comparisons = 0;
   int unsigned seed = 32'h0000_4CF1;
   always #5 clk = ~clk;
   cbc_host #(.SETUP_CYC(1), .STROBE_CYC(3), .HOLD_CYC(1), .RECOV_CYC(1))
   dut_u (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata),
      .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .DATA_I(d_i),
      .DATA_O(d_o), .DATA_OE(oe), .MONITOR_STROBE_N(mon_n),
      .DIRECT_SELECT_N(sel_n), .WRITE_DIR(wdir), .REGISTER_SELECT(rs),
      .ATTENTION_N(att_n));
   cbc_dev_model dev_u (.mon_n(mon_n), .sel_n(sel_n), .wr(wdir),
      .rsel(rs), .dout(d_o), .oe(oe), .din(d_i), .att_n(att_n));
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("Compared %0d, wrong %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic sw(input logic [3:0] a, input logic [31:0] d,
                     input logic w);
      addr <= a;
      wdata <= d;
      wr_stb <= w;
      rd_stb <= !w;
      @(posedge clk);
      wr_stb <= 1'h0;
      rd_stb <= 1'h0;
      #1 v = rdata;
      @(posedge clk);
   endtask
   // Issue one device access, wait for idle, fetch result
   task automatic dev(input logic [5:0] f, input logic [7:0] d);
      int n;
      sw(`CBC_ADDR_CTRL, {18'h0, f, d}, 1'h1);
      for (n = 0; n < 50; n++) begin
         sw(`CBC_ADDR_STATUS, 32'h0, 1'h0);
         if (v[0] === 1'h0) break;
      end
      if (n == 50) begin
         err_total++;
         give_verdict();
      end else begin
         sw(`CBC_ADDR_RESULT, 32'h0, 1'h0);
      end
   endtask
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'h1;
      @(posedge clk);
      sw(`CBC_ADDR_STATUS, 32'h0, 1'h0);
      check(v, 32'h0);
      sw(4'hC, 32'h0, 1'h0);
      check(v, 32'h0);
      for (int k = 0; k < 3; k++) begin
         m = rnd() & 8'hFB;
         dev(6'h06, m);
         dev(6'h02, 8'h00);
         check(v[7:0], m);
         q.push_back(rnd());
         q.push_back(rnd());
         dev(6'h07, q[0]);
         dev(6'h07, q[1]);
         dev(6'h13, 8'h00);
         check(v[15:0], {q[1], q[0]});
         dev(6'h05, 8'h01);
         dev(6'h13, 8'h00);
         check(v[15:0], 16'h0);
         q.delete();
      end
      $display("Test registers done");
      dev(6'h06, 8'h04);
      dev(6'h0C, 8'h10);
      dev(6'h08, 8'h00);
      dev(6'h00, 8'h00);
      check(v[7:0], 8'h10);
      sw(`CBC_ADDR_STATUS, 32'h0, 1'h0);
      check(v[1], 1'h1);
      dev(6'h01, 8'h00);
      check(v[7:0], 8'h04);
      sw(`CBC_ADDR_STATUS, 32'h0, 1'h0);
      check(v[1], 1'h0);
      dev(6'h04, 8'h10);
      dev(6'h05, 8'h01);
      sw(`CBC_ADDR_STATUS, 32'h0, 1'h0);
      check(v[1], 1'h0);
      dev(6'h24, 8'hFF);
      dev(6'h00, 8'h00);
      check(v[7:0], 8'h3F);
      // Receive monitor takes what stands on the bus
      dev(6'h06, 8'h00);
      dev(6'h04, 8'h5A);
      dev(6'h08, 8'h00);
      check(v[7:0], 8'hA5);
      dev(6'h00, 8'h00);
      check(v[7:0], 8'hA5);
      // Request while busy is dropped
      sw(`CBC_ADDR_CTRL, {18'h0, 6'h04, 8'h11}, 1'h1);
      dev(6'h04, 8'h22);
      dev(6'h00, 8'h00);
      check(v[7:0], 8'h11);
      $display("Test monitor done");
      give_verdict();
   end
endmodule
bind cbc_host cbc_host_sva sva_u (.CLK(CLK), .ARST_N(ARST_N),
   .DATA_O(DATA_O), .DATA_OE(DATA_OE), .WRITE_DIR(WRITE_DIR),
   .MONITOR_STROBE_N(MONITOR_STROBE_N), .DIRECT_SELECT_N(DIRECT_SELECT_N),
   .REGISTER_SELECT(REGISTER_SELECT));
`default_nettype wire
